// [core/dre_pkg.sv]
// Shared constants and types for the DMA request sampling and transfer end logic
`default_nettype none
package dre_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned BUS_CLK_DIV = 2;
  localparam int unsigned START_DELAY_BUS_CYCLES = 4;
  localparam int unsigned START_DELAY_CLKS = START_DELAY_BUS_CYCLES * BUS_CLK_DIV;
  localparam int unsigned ACK_LEAD_HALF_CYCLES = 1;
  localparam int unsigned ACK_LEAD_CLKS = ACK_LEAD_HALF_CYCLES * BUS_CLK_DIV / 2;
  localparam int unsigned ADDR_CLKS_DEF = 4;
  // ==========================================================
  // Widths and unit counts
  localparam int unsigned COUNT_W = 24;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned CREDIT_W = 4;
  localparam int unsigned PHASE_W = 8;
  localparam int unsigned UNIT_BYTES = 4;
  localparam int unsigned SIXTEEN_BYTE_UNITS = 4;
  localparam int unsigned BURST_LEVEL_FIRST_UNITS = 2;
  localparam int unsigned SINGLE_UNITS = 1;
  // ==========================================================
  // Reset values
  localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h000000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h00000000;
  // ==========================================================
  // Types
  typedef logic [COUNT_W-1:0] dre_count_t;
  typedef logic [ADDR_W-1:0] dre_addr_t;
  typedef logic [CREDIT_W-1:0] dre_credit_t;
  typedef logic [PHASE_W-1:0] dre_phase_t;
  typedef enum {ENG_IDLE, ENG_DELAY, ENG_READ, ENG_WRITE} dre_eng_e;
endpackage
`default_nettype wire

// [core/dre_req_if.sv]
// Request detector link between the engine and one channel's detector
`timescale 1ns/10ps
`default_nettype none
interface dre_req_if;
  logic sampleStrobe;
  logic pin;
  logic burstMode;
  logic levelDetect;
  logic sixteenByte;
  logic countIsOne;
  logic ackStart;
  logic take;
  logic flush;
  logic idle;
  logic pending;
  modport detector (
    input sampleStrobe, pin, burstMode, levelDetect, sixteenByte, countIsOne,
    input ackStart, take, flush, idle,
    output pending
  );
  modport engine (
    output sampleStrobe, pin, burstMode, levelDetect, sixteenByte, countIsOne,
    output ackStart, take, flush, idle,
    input pending
  );
endinterface // dre_req_if
`default_nettype wire

// [core/dre_req_detect.sv]
// Per-channel request pin detector with transfer credits
`timescale 1ns/10ps
`default_nettype none
module dre_req_detect (
  input wire logic clk,
  input wire logic rst_b,
  dre_req_if.detector req
);
  import dre_pkg::*;
  logic prevPin_reg;
  logic armed_reg;
  logic burstRun_reg;
  logic firstLevel_reg;
  logic [2:0] modeKey_reg;
  dre_credit_t credit_reg;
  dre_credit_t credit_next;
  dre_credit_t grantUnits;
  dre_credit_t usedUnits;
  wire [2:0] modeKey = {req.burstMode, req.levelDetect, req.sixteenByte};
  wire modeChanged = modeKey != modeKey_reg;
  wire burstEdge = req.burstMode && !req.levelDetect;
  wire edgeSeen = req.sampleStrobe && req.pin && !prevPin_reg;
  wire levelSeen = req.sampleStrobe && req.pin;
  wire hit = armed_reg && !modeChanged && (req.levelDetect ? levelSeen : edgeSeen);
  wire quiet = req.idle && (credit_reg == '0) && !burstRun_reg;
  // Cycle-steal and level modes rearm at the first acknowledge after a hit
  wire rearm = req.flush || quiet || (req.ackStart && !burstEdge);
  wire burstFirst = req.burstMode && req.levelDetect && firstLevel_reg && !req.countIsOne;
  // ==========================================================
  // Credits
  assign grantUnits = req.sixteenByte ? CREDIT_W'(SIXTEEN_BYTE_UNITS) :
    burstFirst ? CREDIT_W'(BURST_LEVEL_FIRST_UNITS) : CREDIT_W'(SINGLE_UNITS);
  assign usedUnits = (req.take && !burstRun_reg) ? CREDIT_W'(SINGLE_UNITS) : '0;
  assign credit_next = req.flush ? '0 :
    credit_reg + ((hit && !burstEdge) ? grantUnits : '0) - usedUnits;
  assign req.pending = burstRun_reg || (credit_reg != '0);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prevPin_reg <= 1'b0;
      armed_reg <= 1'b1;
      burstRun_reg <= 1'b0;
      firstLevel_reg <= 1'b1;
      modeKey_reg <= 3'h0;
      credit_reg <= '0;
    end
    else
    begin
      if (req.sampleStrobe)
        prevPin_reg <= req.pin;
      armed_reg <= (modeChanged || hit) ? 1'b0 : (armed_reg || rearm);
      burstRun_reg <= req.flush ? 1'b0 : ((hit && burstEdge) ? 1'b1 : burstRun_reg);
      firstLevel_reg <= (req.flush || quiet) ? 1'b1 : (hit ? 1'b0 : firstLevel_reg);
      modeKey_reg <= modeKey;
      credit_reg <= credit_next;
    end
  end
endmodule // dre_req_detect
`default_nettype wire

// [core/dre_chan_regs.sv]
// Per-channel count, address and end flag registers
`timescale 1ns/10ps
`default_nettype none
module dre_chan_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic countLoad,
  input wire dre_pkg::dre_count_t countLoadValue,
  input wire logic sourceLoad,
  input wire logic destinationLoad,
  input wire dre_pkg::dre_addr_t addressLoadValue,
  input wire logic unitDone,
  input wire logic endClear,
  input wire logic interruptEnable,
  output dre_pkg::dre_count_t transferCount,
  output dre_pkg::dre_addr_t sourceAddress,
  output dre_pkg::dre_addr_t destinationAddress,
  output logic endFlag,
  output logic endInterrupt
);
  import dre_pkg::*;
  logic endFlag_next;
  wire finalUnit = unitDone && (transferCount == COUNT_W'(1));
  // Hardware set wins over a software clear in the same cycle
  assign endFlag_next = finalUnit ? 1'b1 : (endClear ? 1'b0 : endFlag);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      transferCount <= COUNT_RESET;
      sourceAddress <= ADDR_RESET;
      destinationAddress <= ADDR_RESET;
      endFlag <= 1'b0;
      endInterrupt <= 1'b0;
    end
    else
    begin
      if (countLoad)
        transferCount <= countLoadValue;
      else if (unitDone)
        transferCount <= transferCount - COUNT_W'(1);
      if (sourceLoad)
        sourceAddress <= addressLoadValue;
      else if (unitDone)
        sourceAddress <= sourceAddress + ADDR_W'(UNIT_BYTES);
      if (destinationLoad)
        destinationAddress <= addressLoadValue;
      else if (unitDone)
        destinationAddress <= destinationAddress + ADDR_W'(UNIT_BYTES);
      endFlag <= endFlag_next;
      endInterrupt <= endFlag_next && interruptEnable;
    end
  end
endmodule // dre_chan_regs
`default_nettype wire

// [core/dre_top.sv]
// Two-channel DMA request sampling, bus cycle sequencing and transfer end
`timescale 1ns/10ps
`default_nettype none
module dre_top #(
  parameter int unsigned ADDR_CLKS = dre_pkg::ADDR_CLKS_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic masterEnable,
  input wire logic nmiFlag,
  input wire logic addressErrorFlag,
  input wire logic [1:0] channelEnable,
  input wire logic [1:0] endInterruptEnable,
  input wire logic [1:0] burstMode,
  input wire logic [1:0] levelDetect,
  input wire logic [1:0] sixteenByte,
  input wire logic [1:0] dualAddress,
  input wire logic [1:0] ackOnWrite,
  input wire logic busWait,
  input wire logic [1:0] countLoad,
  input wire dre_pkg::dre_count_t countLoadValue,
  input wire logic [1:0] sourceLoad,
  input wire logic [1:0] destinationLoad,
  input wire dre_pkg::dre_addr_t addressLoadValue,
  input wire logic [1:0] transferEndClear,
  input wire logic [1:0] transferRequestPin,
  output logic externalBusClock,
  output logic [1:0] transferAcknowledgePin,
  output dre_pkg::dre_addr_t busAddress,
  output logic busWrite,
  output logic busCycleActive,
  output logic cpuBusHeld,
  output logic [1:0] transferEndFlag,
  output logic [1:0] transferEndInterrupt,
  output dre_pkg::dre_count_t transferCount0,
  output dre_pkg::dre_count_t transferCount1,
  output dre_pkg::dre_addr_t sourceAddress0,
  output dre_pkg::dre_addr_t sourceAddress1,
  output dre_pkg::dre_addr_t destinationAddress0,
  output dre_pkg::dre_addr_t destinationAddress1
);
  import dre_pkg::*;

  // ==========================================================
  // Helpers
  function automatic dre_phase_t phaseLoad(input int unsigned clks);
    phaseLoad = PHASE_W'(clks - 1);
  endfunction

  function automatic logic pickOther(input logic ch);
    pickOther = !ch;
  endfunction

  // ==========================================================
  // Declarations
  dre_eng_e state_reg;
  dre_eng_e state_next;
  dre_phase_t phase_reg;
  dre_phase_t phase_next;
  logic activeCh_reg;
  logic activeCh_next;
  logic busClk_reg;
  logic [1:0] haltLatch_reg;
  logic [1:0] take;
  logic [1:0] unitDone;
  logic [1:0] ackStart;
  logic [1:0] reqPending;
  logic [1:0] countZero;
  logic [1:0] countIsOne;
  logic [1:0] eligible;
  logic [1:0] flush;
  logic [1:0] chanIdle;
  logic [1:0] ackCond;
  dre_count_t countArr [2];
  dre_addr_t srcArr [2];
  dre_addr_t dstArr [2];
  dre_addr_t addrSel;
  logic writeSel;
  logic cycleSel;
  logic heldNext;

  // ==========================================================
  // External bus clock
  // The link clock is clk divided by two; the edge that takes it low is
  // the edge at which the request pins are sampled.
  wire sampleStrobe = busClk_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      busClk_reg <= 1'b0;
    else
      busClk_reg <= !busClk_reg;
  end

  // ==========================================================
  // Global stop and channel eligibility
  wire runOk = masterEnable && !nmiFlag && !addressErrorFlag;
  wire errorStop = nmiFlag || addressErrorFlag;
  wire inCycle = (state_reg == ENG_READ) || (state_reg == ENG_WRITE);
  wire cycEnd = inCycle && (phase_reg == '0) && !busWait;
  wire activeDual = dualAddress[activeCh_reg];
  wire activeEnabled = channelEnable[activeCh_reg];
  wire ackInPhase = (phase_reg >= PHASE_W'(ACK_LEAD_CLKS)) || busWait;
  wire anyEligible = |eligible;
  wire pick = eligible[0] ? 1'b0 : 1'b1;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_chan
      dre_req_if reqIf ();

      assign countZero[gi] = countArr[gi] == '0;
      assign countIsOne[gi] = countArr[gi] == COUNT_W'(1);
      // A stopped channel stays out until software drops and re-sets its enable
      assign eligible[gi] = channelEnable[gi] && !haltLatch_reg[gi]
        && !countZero[gi] && reqPending[gi];
      assign chanIdle[gi] = (state_reg == ENG_IDLE) || (activeCh_reg != gi[0]);
      assign flush[gi] = (unitDone[gi] && countIsOne[gi]) || haltLatch_reg[gi]
        || !channelEnable[gi];
      assign ackStart[gi] = ackCond[gi] && !transferAcknowledgePin[gi];

      assign reqIf.sampleStrobe = sampleStrobe;
      assign reqIf.pin = transferRequestPin[gi];
      assign reqIf.burstMode = burstMode[gi];
      assign reqIf.levelDetect = levelDetect[gi];
      assign reqIf.sixteenByte = sixteenByte[gi];
      assign reqIf.countIsOne = countIsOne[gi];
      assign reqIf.ackStart = ackStart[gi];
      assign reqIf.take = take[gi];
      assign reqIf.flush = flush[gi];
      assign reqIf.idle = chanIdle[gi];
      assign reqPending[gi] = reqIf.pending;

      dre_req_detect u_detect (
        .clk (clk),
        .rst_b (rst_b),
        .req (reqIf)
      );

      dre_chan_regs u_regs (
        .clk (clk),
        .rst_b (rst_b),
        .countLoad (countLoad[gi]),
        .countLoadValue (countLoadValue),
        .sourceLoad (sourceLoad[gi]),
        .destinationLoad (destinationLoad[gi]),
        .addressLoadValue (addressLoadValue),
        .unitDone (unitDone[gi]),
        .endClear (transferEndClear[gi]),
        .interruptEnable (endInterruptEnable[gi]),
        .transferCount (countArr[gi]),
        .sourceAddress (srcArr[gi]),
        .destinationAddress (dstArr[gi]),
        .endFlag (transferEndFlag[gi]),
        .endInterrupt (transferEndInterrupt[gi])
      );

      // Hardware stop wins over the enable clear that would release it
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          haltLatch_reg[gi] <= 1'b0;
        else if (errorStop)
          haltLatch_reg[gi] <= 1'b1;
        else if (!channelEnable[gi])
          haltLatch_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  assign transferCount0 = countArr[0];
  assign transferCount1 = countArr[1];
  assign sourceAddress0 = srcArr[0];
  assign sourceAddress1 = srcArr[1];
  assign destinationAddress0 = dstArr[0];
  assign destinationAddress1 = dstArr[1];

  // ==========================================================
  // Bus cycle sequencer
  // Arbitration: channel 0 wins whenever both are eligible. A burst keeps
  // the bus by coming straight back from idle while its credit or its edge-mode burst run lasts.
  always_comb
  begin
    state_next = state_reg;
    phase_next = phase_reg;
    activeCh_next = activeCh_reg;
    take = 2'b00;
    unitDone = 2'b00;
    case (state_reg)
      ENG_IDLE:
      begin
        if (runOk && anyEligible)
        begin
          take[pick] = 1'b1;
          activeCh_next = pick;
          phase_next = phaseLoad(START_DELAY_CLKS);
          state_next = ENG_DELAY;
        end
      end
      ENG_DELAY:
      begin
        if (!runOk || !activeEnabled)
          state_next = ENG_IDLE;
        else if (phase_reg == '0)
        begin
          phase_next = phaseLoad(ADDR_CLKS);
          if (activeDual || !ackOnWrite[activeCh_reg])
            state_next = ENG_READ;
          else
            state_next = ENG_WRITE;
        end
        else
          phase_next = phase_reg - PHASE_W'(1);
      end
      ENG_READ:
      begin
        if (cycEnd)
        begin
          if (!activeDual)
          begin
            unitDone[activeCh_reg] = 1'b1;
            state_next = ENG_IDLE;
          end
          else if (!masterEnable || !activeEnabled)
            state_next = ENG_IDLE;
          else
          begin
            // An address error here still lets the write half complete
            phase_next = phaseLoad(ADDR_CLKS);
            state_next = ENG_WRITE;
          end
        end
        else if (!busWait)
          phase_next = phase_reg - PHASE_W'(1);
      end
      ENG_WRITE:
      begin
        if (cycEnd)
        begin
          unitDone[activeCh_reg] = 1'b1;
          state_next = ENG_IDLE;
        end
        else if (!busWait)
          phase_next = phase_reg - PHASE_W'(1);
      end
      default:
      begin
        state_next = ENG_IDLE;
        phase_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= ENG_IDLE;
      phase_reg <= '0;
      activeCh_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      activeCh_reg <= activeCh_next;
    end
  end

  // ==========================================================
  // Acknowledge and address outputs
  // Every bus output except cpuBusHeld and externalBusClock is registered from the same state, so address and
  // acknowledge stay aligned; that group trails the sequencer by one clk, while cpuBusHeld is registered from state_next and does not.
  wire readAck = !activeDual || !ackOnWrite[activeCh_reg];
  wire writeAck = !activeDual || ackOnWrite[activeCh_reg];
  wire ackNow = ackInPhase && (((state_reg == ENG_READ) && readAck)
    || ((state_reg == ENG_WRITE) && writeAck));

  assign ackCond[0] = ackNow && (activeCh_reg == 1'b0);
  assign ackCond[1] = ackNow && (activeCh_reg == 1'b1);
  assign writeSel = state_reg == ENG_WRITE;
  assign cycleSel = inCycle;
  assign addrSel = writeSel ? dstArr[activeCh_reg] : srcArr[activeCh_reg];
  // A steady request keeps a credit ready, so the CPU never gets a gap
  assign heldNext = (state_next != ENG_IDLE) || (runOk && anyEligible);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      transferAcknowledgePin <= 2'b00;
      busAddress <= ADDR_RESET;
      busWrite <= 1'b0;
      busCycleActive <= 1'b0;
      cpuBusHeld <= 1'b0;
    end
    else
    begin
      transferAcknowledgePin <= ackCond;
      busAddress <= cycleSel ? addrSel : ADDR_RESET;
      busWrite <= writeSel;
      busCycleActive <= cycleSel;
      cpuBusHeld <= heldNext;
    end
  end

  assign externalBusClock = busClk_reg;

  // ==========================================================
  // Notes on limits
  // Only one unit per channel is ever in flight. Credits granted by the
  // detector survive a channel enable drop only until the flush that follows it,
  // so a halted channel never resumes on a stale request. The other
  // channel's index is kept available for round-robin extensions.
  wire unusedOther = pickOther(activeCh_reg);
  logic unusedSink_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      unusedSink_reg <= 1'b0;
    else
      unusedSink_reg <= unusedOther;
  end
endmodule // dre_top
`default_nettype wire

// [verification/dre_partner.sv]
// Peripheral model that raises transfer requests and watches acknowledge
`timescale 1ns/10ps
`default_nettype none
module dre_partner (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] fire,
  input wire logic [1:0] keepHigh,
  input wire logic [1:0] ack,
  output logic [1:0] pin
);
  // ==========================================================
  // Request pins
  // A pulse request stays up until acknowledged; keepHigh models a level source
  // Kept apart so a dropped level source really lets the pin fall
  logic [1:0] pulse_reg;
  logic [1:0] pulse_next;
  assign pulse_next = (fire | pulse_reg) & ~ack;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pulse_reg <= 2'h0;
      pin <= 2'h0;
    end
    else
    begin
      pulse_reg <= pulse_next;
      pin <= keepHigh | pulse_next;
    end
  end
endmodule // dre_partner
`default_nettype wire

// [verification/dre_top_asserts.sv]
// Concurrent checks on the ports of the request sampling and transfer end block
`timescale 1ns/10ps
`default_nettype none
module dre_top_asserts #(
  parameter int unsigned ADDR_CLKS = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic masterEnable,
  input wire logic nmiFlag,
  input wire logic busWait,
  input wire logic [1:0] countLoad,
  input wire logic [1:0] transferAcknowledgePin,
  input wire logic busCycleActive,
  input wire logic busWrite,
  input wire logic externalBusClock,
  input wire logic [1:0] transferEndFlag,
  input wire logic [1:0] transferEndInterrupt,
  input wire dre_pkg::dre_count_t transferCount0,
  input wire dre_pkg::dre_count_t transferCount1
);
  import dre_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [3:0] idleCnt;
  // ==========================================================
  // Idle run length before each bus cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      idleCnt <= 4'h0;
    else if (busCycleActive)
      idleCnt <= 4'h0;
    else if (idleCnt != 4'hF)
      idleCnt <= idleCnt + 4'h1;
  end
  // ==========================================================
  // Assertions
  busclk_toggle_a: assert property ($past(rst_b) |->
    externalBusClock != $past(externalBusClock))
    else $error("bus clock did not toggle");
  start_gap_a: assert property ($rose(busCycleActive) |-> idleCnt >= 4'h8)
    else $error("bus cycle started too soon");
  ack_in_cycle_a: assert property (|transferAcknowledgePin |-> busCycleActive)
    else $error("acknowledge outside bus cycle");
  ack_lead_a: assert property ($fell(busCycleActive) && !$past(busWait)
    |-> $past(transferAcknowledgePin) == 2'h0)
    else $error("acknowledge not dropped before address end");
  count_step_a: assert property ($changed(transferCount0) && !$past(countLoad[0])
    |-> transferCount0 == $past(transferCount0) - 24'h1)
    else $error("count moved by other than one");
  end_zero_a: assert property ($rose(transferEndFlag[0]) |-> transferCount0 == 24'h0)
    else $error("end flag set with nonzero count");
  end_zero_one_a: assert property ($rose(transferEndFlag[1]) |-> transferCount1 == 24'h0)
    else $error("end flag set with nonzero count");
  write_in_cycle_a: assert property (busWrite |-> busCycleActive)
    else $error("write strobe outside bus cycle");
  irq_flag_a: assert property ($rose(transferEndInterrupt[0]) |-> transferEndFlag[0])
    else $error("interrupt without end flag");
  halt_stop_a: assert property ($rose(nmiFlag) && !busWait |-> ##[0:20] !busCycleActive)
    else $error("bus still busy after halt");
  halt_hold_a: assert property (nmiFlag && $past(nmiFlag) && $past(nmiFlag, 2)
    |-> !$rose(busCycleActive))
    else $error("bus cycle started while halted");
  master_off_a: assert property (!masterEnable && !$past(masterEnable) && !$past(masterEnable, 2)
    |-> !$rose(busCycleActive))
    else $error("bus cycle started with master off");
  cover property ($rose(transferEndFlag[0]));
  cover property ($rose(transferEndInterrupt[0]));
  cover property ($rose(nmiFlag) && busCycleActive);
endmodule // dre_top_asserts
bind dre_top dre_top_asserts #(.ADDR_CLKS(ADDR_CLKS)) dre_top_asserts_i (.clk(clk),
  .rst_b(rst_b), .masterEnable(masterEnable), .nmiFlag(nmiFlag), .busWait(busWait),
  .countLoad(countLoad), .transferAcknowledgePin(transferAcknowledgePin),
  .busCycleActive(busCycleActive), .busWrite(busWrite), .externalBusClock(externalBusClock),
  .transferEndFlag(transferEndFlag), .transferEndInterrupt(transferEndInterrupt),
  .transferCount0(transferCount0), .transferCount1(transferCount1));
`default_nettype wire

// [verification/dre_tb_top.sv]
// Self-checking bench for the request sampling and transfer end block
`timescale 1ns/10ps
`default_nettype none
module dre_tb_top;
  import dre_pkg::*;
  logic clk, rst_b, masterEnable, nmiFlag, addrErr, busWait, bclk, busWrite, active, held;
  logic [1:0] chEn, ie, burst, level, six, dual, ackWr, cLd, sLd, dLd, endClr;
  logic [1:0] pin, ack, fire, keepHigh, endFlag, endIrq;
  dre_count_t cntVal, count0, count1;
  dre_addr_t addrVal, busAddress, src0, src1, dst0, dst1;
  logic prevActive;
  int fails, checks, units, base, n;
  dre_top dre_top_i (.clk(clk), .rst_b(rst_b), .masterEnable(masterEnable), .nmiFlag(nmiFlag),
    .addressErrorFlag(addrErr), .channelEnable(chEn), .endInterruptEnable(ie),
    .burstMode(burst), .levelDetect(level), .sixteenByte(six), .dualAddress(dual),
    .ackOnWrite(ackWr), .busWait(busWait), .countLoad(cLd), .countLoadValue(cntVal),
    .sourceLoad(sLd), .destinationLoad(dLd), .addressLoadValue(addrVal),
    .transferEndClear(endClr), .transferRequestPin(pin), .externalBusClock(bclk),
    .transferAcknowledgePin(ack), .busAddress(busAddress), .busWrite(busWrite),
    .busCycleActive(active), .cpuBusHeld(held), .transferEndFlag(endFlag),
    .transferEndInterrupt(endIrq), .transferCount0(count0), .transferCount1(count1),
    .sourceAddress0(src0), .sourceAddress1(src1), .destinationAddress0(dst0),
    .destinationAddress1(dst1));
  dre_partner dre_partner_i (.clk(clk), .rst_b(rst_b), .fire(fire), .keepHigh(keepHigh),
    .ack(ack), .pin(pin));
  // ==========================================================
  // Clock and bus cycle counter
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    prevActive <= active;
    if (active && !prevActive)
      units <= units + 1;
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic time_out;
    fails++;
    complete_run;
  endtask
  // Bounded: a stuck bus ends the run instead of hanging
  task automatic idle_wait;
    int q;
    int k;
    q = 0;
    k = 0;
    while (q < 30)
    begin
      @(posedge clk);
      k++;
      q = active ? 0 : q + 1;
      if (k > 3000)
        time_out;
    end
  endtask
  task automatic setup(input int ch, input logic b, l, s, d, input dre_count_t cnt);
    @(posedge clk);
    chEn[ch] <= 1'b0;
    burst[ch] <= b;
    level[ch] <= l;
    six[ch] <= s;
    dual[ch] <= d;
    cLd[ch] <= 1'b1;
    cntVal <= cnt;
    sLd[ch] <= 1'b1;
    addrVal <= 32'h00001000;
    endClr[ch] <= 1'b1;
    @(posedge clk);
    cLd[ch] <= 1'b0;
    sLd[ch] <= 1'b0;
    dLd[ch] <= 1'b1;
    addrVal <= 32'h00002000;
    @(posedge clk);
    dLd[ch] <= 1'b0;
    endClr[ch] <= 1'b0;
    chEn[ch] <= 1'b1;
    @(posedge clk);
    base = units;
  endtask
  task automatic fire_req(input int ch);
    @(posedge clk);
    fire[ch] <= 1'b1;
    @(posedge clk);
    fire[ch] <= 1'b0;
  endtask
  // ==========================================================
  // Scenarios
  task automatic test_cs_edge;
    int k;
    setup(0, 1'b0, 1'b0, 1'b0, 1'b1, 24'h000002);
    ie[0] <= 1'b1;
    fire_req(0);
    for (k = 0; k < 100 && !active; k++)
      @(posedge clk);
    if (!active)
      time_out;
    chk(busAddress, 32'h00001000);
    chk(32'(ack), 32'h1);
    chk(32'(held), 32'h1);
    repeat (4) @(posedge clk);
    chk(32'(busWrite), 32'h1);
    chk(busAddress, 32'h00002000);
    chk(32'(ack), 32'h0);
    idle_wait;
    chk(units - base, 1);
    chk(32'(count0), 1);
    chk(src0, 32'h00001004);
    chk(dst0, 32'h00002004);
    fire_req(0);
    idle_wait;
    chk(units - base, 2);
    chk(32'(endFlag[0]), 1);
    chk(32'(endIrq[0]), 1);
    chk(32'(held), 0);
    $display("test_cs_edge done");
  endtask
  task automatic test_sixteen;
    setup(1, 1'b0, 1'b1, 1'b1, 1'b0, 24'h000004);
    ackWr[1] <= 1'b1;
    fire_req(1);
    idle_wait;
    chk(units - base, 4);
    chk(32'(endFlag[1]), 1);
    chk(32'(endIrq[1]), 0);
    chk(dst1, 32'h00002010);
    $display("test_sixteen done");
  endtask
  task automatic test_burst_edge;
    setup(1, 1'b1, 1'b0, 1'b0, 1'b0, 24'h000003);
    fire_req(1);
    repeat (14) @(posedge clk);
    busWait <= 1'b1;
    repeat (3) @(posedge clk);
    busWait <= 1'b0;
    idle_wait;
    chk(units - base, 3);
    chk(32'(count1), 0);
    chk(32'(endFlag[1]), 1);
    $display("test_burst_edge done");
  endtask
  task automatic test_level;
    int k;
    for (k = 1; k <= 3; k += 2)
    begin
      setup(0, 1'b1, 1'b1, 1'b0, 1'b1, 24'(k));
      keepHigh[0] <= 1'b1;
      idle_wait;
      keepHigh[0] <= 1'b0;
      chk(units - base, k);
      chk(32'(endFlag[0]), 1);
    end
    $display("test_level done");
  endtask
  task automatic test_halt;
    int k;
    int j;
    for (k = 0; k < 3; k++)
    begin
      setup(0, 1'b1, 1'b0, 1'b0, 1'b0, 24'h000008);
      fire_req(0);
      for (j = 0; j < 100 && units == base; j++)
        @(posedge clk);
      if (units == base)
        time_out;
      repeat (2) @(posedge clk);
      if (k == 0)
        chEn[0] <= 1'b0;
      else if (k == 1)
        nmiFlag <= 1'b1;
      else
        masterEnable <= 1'b0;
      idle_wait;
      n = units - base;
      chk(32'(count0) + n, 8);
      chk(src0, 32'h00001000 + 4 * n);
      chk(32'(endFlag[0]), 0);
      nmiFlag <= 1'b0;
      masterEnable <= 1'b1;
      idle_wait;
      if (k == 1)
        chk(units - base, n);
    end
    $display("test_halt done");
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    {rst_b, nmiFlag, addrErr, busWait, chEn, ie, burst, level, six, dual} = '0;
    {ackWr, cLd, sLd, dLd, endClr, fire, keepHigh, cntVal, addrVal} = '0;
    {fails, checks, units, base, n} = '0;
    prevActive = 1'b0;
    masterEnable = 1'b1;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    test_cs_edge;
    test_sixteen;
    test_burst_edge;
    test_level;
    test_halt;
    complete_run;
  end
endmodule // dre_tb_top
`default_nettype wire
